/* verilog/cba_addr_phase.sv */
// address-phase engine of the synchronous system bus
// Functional notes
// - address valid with strobe, held until next-address or last transfer-ready
// - address keeps driving while idle unless floated
// - snoop address bits 31..5 captured on snoop strobe; far end drives 4..3
// - address floats on release, backoff or hold grant; resumes on negation
// - strobe asserted exactly one clock per cycle with address
// - non-pipelined: new cycle only after edge of last transfer-ready
// - pipelined: strobe may follow next-address by one edge
// - under address release only snoop-hit writebacks may start
// - strobe floats on backoff and hold grant
// - duplicate strobe identical to primary
// - release floats only address and parity
// - release sampled every edge, also during reset
// - parity even across parity bit and address 31..5
// - parity held and floated like the address
// - snoop parity sampled with snoop strobe and checked
// - parity error one-clock pulse the edge after snoop strobe
// - parity error output registered, glitch-free
// - lane enable n covers data byte n, active low
// - lane enables held like address, not floated by release
// - straps decode to core ratio 2.5x..6.0x, default 3.5x
// - straps latched at reset release
`timescale 1ns/1ps
module cba_addr_phase
  import cba_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire cba_req_type req,
  input wire logic next_address_ok_n,
  input wire logic transfer_ready_in_n,
  input wire logic external_snoop_strobe_n,
  input wire logic address_release_req,
  input wire logic bus_backoff_n,
  input wire logic hold_req,
  output logic hold_grant,
  input wire logic [31:3] addr_in,
  output logic [31:3] addr_out,
  output logic addr_oe,
  input wire logic addr_parity_in,
  output logic addr_parity_out,
  output logic addr_parity_oe,
  output logic [7:0] byte_lane_enables_n,
  output logic lanes_oe,
  output logic cycle_start_strobe_n,
  output logic cycle_start_strobe_dup_n,
  output logic strobe_oe,
  output logic addr_parity_error_out_n,
  output logic snoop_valid,
  output logic [31:5] snoop_addr,
  input wire logic [2:0] core_ratio_select,
  output logic [3:0] core_ratio_x2
);
  typedef enum logic [1:0] {IDLE, ACTIVE, PIPE} cba_state_type;
  cba_state_type state;
  logic [2:0] beats_left;
  logic [2:0] pipe_beats;
  logic ready_seen;
  logic na_seen;
  logic backoff;
  logic release_on;
  logic last_ready;
  logic start;
  logic na_flag;
  logic release_q;
  logic drive_q;
  cba_addr_type hold_addr;

  assign backoff = !bus_backoff_n;
  assign release_on = address_release_req;
  assign ready_seen = !transfer_ready_in_n && state != IDLE && !backoff;
  assign last_ready = ready_seen && beats_left == 3'h1;
  assign na_seen = !next_address_ok_n && state == ACTIVE;

  // new cycle: bus owned, at most one pipelined behind the active one, release lets only writebacks out
  always_comb begin
    req_ready = !backoff && !hold_grant && !hold_req && cycle_start_strobe_n
      && (state == IDLE || (state == ACTIVE && na_flag))
      && (!release_on || req.writeback);
  end
  assign start = req_valid && req_ready;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      na_flag <= 1'b0;
    end else if (start || last_ready || backoff) begin
      na_flag <= 1'b0;
    end else if (na_seen) begin
      na_flag <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_grant <= 1'b0;
    end else begin
      hold_grant <= hold_req && (state == IDLE || hold_grant);
    end
  end

  // cycle tracking; backoff aborts, the cycle is resubmitted by the core
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= IDLE;
      beats_left <= 3'h0;
      pipe_beats <= 3'h0;
    end else if (backoff) begin
      state <= IDLE;
      beats_left <= 3'h0;
    end else begin
      case (state)
        IDLE: begin
          if (start) begin
            state <= ACTIVE;
            beats_left <= req.burst ? 3'h4 : 3'h1;
          end
        end
        ACTIVE: begin
          if (start) begin
            state <= PIPE;
            pipe_beats <= req.burst ? 3'h4 : 3'h1;
          end
          if (last_ready) begin
            state <= start ? ACTIVE : IDLE;
            beats_left <= req.burst ? 3'h4 : 3'h1;
          end else if (ready_seen) begin
            beats_left <= beats_left - 3'h1;
          end
        end
        PIPE: begin
          if (last_ready) begin
            state <= ACTIVE;
            beats_left <= pipe_beats;
          end else if (ready_seen) begin
            beats_left <= beats_left - 3'h1;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // address, parity and lanes change only at a start; idle keeps the last value
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_addr <= '0;
      byte_lane_enables_n <= 8'hff;
    end else if (start) begin
      hold_addr.addr <= req.addr;
      hold_addr.parity <= even_par(req.addr[31:5]);
      byte_lane_enables_n <= req.lanes_n;
    end
  end
  assign addr_out = hold_addr.addr;
  assign addr_parity_out = hold_addr.parity;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cycle_start_strobe_n <= 1'b1;
    end else begin
      cycle_start_strobe_n <= !start;
    end
  end
  assign cycle_start_strobe_dup_n = cycle_start_strobe_n;

  // output enables registered so float/resume happens off the sampling edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      drive_q <= 1'b1;
      lanes_oe <= 1'b1;
      strobe_oe <= 1'b1;
    end else begin
      drive_q <= !(backoff || (hold_req && (state == IDLE || hold_grant)));
      lanes_oe <= !(backoff || (hold_req && (state == IDLE || hold_grant)));
      strobe_oe <= !(backoff || (hold_req && (state == IDLE || hold_grant)));
    end
  end
  // no reset on purpose: release must float the address even while rst is high
  always_ff @(posedge ref_clk) begin
    release_q <= release_on;
  end
  assign addr_oe = drive_q && !release_q;
  assign addr_parity_oe = addr_oe;

  cba_snoop_check u_snoop (
    .ref_clk(ref_clk),
    .rst(rst),
    .snoop_ok(!addr_oe),
    .external_snoop_strobe_n(external_snoop_strobe_n),
    .addr_in(addr_in),
    .addr_parity_in(addr_parity_in),
    .snoop_valid(snoop_valid),
    .snoop_addr(snoop_addr),
    .addr_parity_error_out_n(addr_parity_error_out_n)
  );

  cba_ratio_latch u_ratio (
    .ref_clk(ref_clk),
    .rst(rst),
    .core_ratio_select(core_ratio_select),
    .core_ratio_x2(core_ratio_x2)
  );

  chk_strobe_one: assert property (@(posedge ref_clk) disable iff (rst)
    !cycle_start_strobe_n |=> cycle_start_strobe_n) else $error("strobe wider than one clock");
  chk_addr_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (!cycle_start_strobe_n ##1 !start) |-> $stable(addr_out)) else $error("address moved");
  chk_release_float: assert property (@(posedge ref_clk) disable iff (rst)
    address_release_req |=> !addr_oe && !addr_parity_oe) else $error("release not floating");
  chk_release_lanes: assert property (@(posedge ref_clk) disable iff (rst)
    (address_release_req && bus_backoff_n && !hold_req && !hold_grant) |=> lanes_oe && strobe_oe)
    else $error("release floated lanes");
  chk_backoff_float: assert property (@(posedge ref_clk) disable iff (rst)
    !bus_backoff_n |=> !strobe_oe && !lanes_oe) else $error("backoff not floating");
  chk_release_wb: assert property (@(posedge ref_clk) disable iff (rst)
    (start && address_release_req) |-> req.writeback) else $error("non-writeback under release");
  chk_parity_even: assert property (@(posedge ref_clk) disable iff (rst)
    !cycle_start_strobe_n |-> (^{addr_out[31:5], addr_parity_out}) == 1'b0)
    else $error("address parity odd");
  chk_idle_gap: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ACTIVE && last_ready && !na_flag) |-> !start) else $error("no idle state");
  chk_dup_same: assert property (@(posedge ref_clk) disable iff (rst)
    cycle_start_strobe_dup_n == cycle_start_strobe_n) else $error("strobe copy differs");
  chk_hold_float: assert property (@(posedge ref_clk) disable iff (rst)
    hold_grant |-> !addr_oe && !lanes_oe && !strobe_oe) else $error("hold not floating");
  chk_backoff_addr: assert property (@(posedge ref_clk) disable iff (rst)
    !bus_backoff_n |=> !addr_oe && !addr_parity_oe) else $error("backoff kept address");
  chk_release_resume: assert property (@(posedge ref_clk) disable iff (rst)
    ($fell(address_release_req) && bus_backoff_n && !hold_req && !hold_grant) |=> addr_oe)
    else $error("address not resumed");
  chk_snoop_capture: assert property (@(posedge ref_clk) disable iff (rst)
    (!addr_oe && !external_snoop_strobe_n) |=> snoop_valid && snoop_addr == $past(addr_in[31:5]))
    else $error("snoop address not taken");
  chk_lanes_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (!cycle_start_strobe_n ##1 !start) |-> $stable(byte_lane_enables_n))
    else $error("lanes moved");
endmodule

/* include/cba_pkg.sv */
// package for the bus address-phase block
package cba_pkg;
  localparam int ADDR_HI = 31;
  localparam int ADDR_LO = 3;
  localparam int SNOOP_LO = 5;
  localparam int LANES = 8;
  // core ratio in half steps (ratio x 2)
  localparam logic [3:0] RATIO_2P5 = 4'h5;
  localparam logic [3:0] RATIO_3P0 = 4'h6;
  localparam logic [3:0] RATIO_3P5 = 4'h7;
  localparam logic [3:0] RATIO_4P0 = 4'h8;
  localparam logic [3:0] RATIO_4P5 = 4'h9;
  localparam logic [3:0] RATIO_5P0 = 4'ha;
  localparam logic [3:0] RATIO_5P5 = 4'hb;
  localparam logic [3:0] RATIO_6P0 = 4'hc;
  localparam logic [2:0] STRAP_DEFAULT = 3'h7;
  localparam real STRAP_SETUP_MS = 1.0;
  localparam int STRAP_HOLD_CLKS = 2;

  typedef struct packed {
    logic [31:3] addr;
    logic [7:0] lanes_n;
    logic burst;
    logic writeback;
  } cba_req_type;

  typedef struct packed {
    logic [31:3] addr;
    logic parity;
  } cba_addr_type;

  function automatic logic even_par(input logic [31:5] a);
    even_par = ^a;
  endfunction
endpackage

/* verilog/cba_ratio_latch.sv */
// latches the core ratio straps at reset release
`timescale 1ns/1ps
module cba_ratio_latch
  import cba_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] core_ratio_select,
  output logic [3:0] core_ratio_x2
);
  logic armed;
  // straps are caught by the clock at release, never by the async reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      armed <= 1'b1;
    end else begin
      armed <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      core_ratio_x2 <= RATIO_3P5;
    end else if (armed) begin
      case (core_ratio_select)
        3'h4: core_ratio_x2 <= RATIO_2P5;
        3'h5: core_ratio_x2 <= RATIO_3P0;
        3'h7: core_ratio_x2 <= RATIO_3P5;
        3'h2: core_ratio_x2 <= RATIO_4P0;
        3'h0: core_ratio_x2 <= RATIO_4P5;
        3'h1: core_ratio_x2 <= RATIO_5P0;
        3'h3: core_ratio_x2 <= RATIO_5P5;
        default: core_ratio_x2 <= RATIO_6P0;
      endcase
    end
  end

  chk_ratio_frozen: assert property (@(posedge ref_clk) disable iff (rst)
    (!armed && !$past(armed)) |-> $stable(core_ratio_x2))
    else $error("ratio changed after release");
  chk_ratio_default: assert property (@(posedge ref_clk) disable iff (rst)
    (armed && core_ratio_select == 3'h7) |=> core_ratio_x2 == RATIO_3P5)
    else $error("default ratio wrong");
endmodule

/* verilog/cba_snoop_check.sv */
// inquire address capture and parity check
`timescale 1ns/1ps
module cba_snoop_check
  import cba_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic snoop_ok,
  input wire logic external_snoop_strobe_n,
  input wire logic [31:3] addr_in,
  input wire logic addr_parity_in,
  output logic snoop_valid,
  output logic [31:5] snoop_addr,
  output logic addr_parity_error_out_n
);
  logic bad;
  assign bad = (even_par(addr_in[31:5]) ^ addr_parity_in) != 1'b0;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      snoop_valid <= 1'b0;
      snoop_addr <= '0;
    end else begin
      snoop_valid <= snoop_ok && !external_snoop_strobe_n;
      if (snoop_ok && !external_snoop_strobe_n) begin
        snoop_addr <= addr_in[31:5];
      end
    end
  end

  // registered so the pin never glitches and may clock system logic
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_parity_error_out_n <= 1'b1;
    end else begin
      addr_parity_error_out_n <= !(snoop_ok && !external_snoop_strobe_n && bad);
    end
  end

  chk_parity_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    (snoop_ok && !external_snoop_strobe_n && bad) |=> !addr_parity_error_out_n)
    else $error("parity error not flagged");
  chk_parity_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    !(snoop_ok && !external_snoop_strobe_n && bad) |=> addr_parity_error_out_n)
    else $error("spurious parity error");
endmodule

/* test/cba_chipset_model.sv */
// far-side chipset model answering bus cycles with transfer-ready and next-address
`timescale 1ns/1ps
module cba_chipset_model
  import cba_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cycle_start_strobe_n,
  input wire logic burst,
  input wire logic [3:0] wait_states,
  input wire logic na_en,
  output logic transfer_ready_in_n = 1'b1,
  output logic next_address_ok_n = 1'b1
);
  int beats = 0;
  int cnt = 0;
  logic na_pend = 1'b0;
  // both lines idle high as their pullups would leave them
  always @(negedge ref_clk) begin
    transfer_ready_in_n <= 1'b1;
    next_address_ok_n <= 1'b1;
    if (rst) begin
      beats <= 0;
    end else if (!cycle_start_strobe_n) begin
      // beats add up, so a pipelined start does not lose the earlier cycle
      beats <= beats + (burst ? 4 : 1);
      cnt <= wait_states;
      na_pend <= na_en;
    end else if (beats > 0) begin
      next_address_ok_n <= !na_pend;
      na_pend <= 1'b0;
      if (cnt > 0) begin
        cnt <= cnt - 1;
      end else begin
        transfer_ready_in_n <= 1'b0;
        beats <= beats - 1;
      end
    end
  end
endmodule

/* test/cba_addr_phase_tb.sv */
// self-checking bench for the address-phase block
`timescale 1ns/1ps
module cba_addr_phase_tb;
  import cba_pkg::*;
  logic ref_clk = 0, rst = 1, req_valid = 0, external_snoop_strobe_n = 1, na_en = 0;
  logic address_release_req = 0, bus_backoff_n = 1, hold_req = 0, snp_par = 0;
  logic req_ready, next_address_ok_n, transfer_ready_in_n, hold_grant, addr_oe, lanes_oe;
  logic addr_parity_in, addr_parity_out, addr_parity_oe, strobe_oe, snoop_valid;
  logic cycle_start_strobe_n, cycle_start_strobe_dup_n, addr_parity_error_out_n;
  logic [31:3] addr_in, addr_out, snp = '0;
  logic [31:5] snoop_addr;
  logic [7:0] byte_lane_enables_n;
  logic [2:0] core_ratio_select = STRAP_DEFAULT;
  logic [3:0] core_ratio_x2, ws = 4'h2;
  cba_req_type req = '0;
  int miscompares = 0, n_tests = 0, cyc = 0, last_rdy = -9, last_na = -9;
  // the snoop source owns the pins whenever the block lets go of them
  assign addr_in = addr_oe ? addr_out : snp;
  assign addr_parity_in = addr_parity_oe ? addr_parity_out : snp_par;
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (!transfer_ready_in_n) last_rdy <= cyc;
    if (!next_address_ok_n) last_na <= cyc;
  end
  cba_addr_phase dut (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .next_address_ok_n(next_address_ok_n),
    .transfer_ready_in_n(transfer_ready_in_n), .external_snoop_strobe_n(external_snoop_strobe_n),
    .address_release_req(address_release_req), .bus_backoff_n(bus_backoff_n),
    .hold_req(hold_req), .hold_grant(hold_grant), .addr_in(addr_in), .addr_out(addr_out),
    .addr_oe(addr_oe), .addr_parity_in(addr_parity_in), .addr_parity_out(addr_parity_out),
    .addr_parity_oe(addr_parity_oe), .byte_lane_enables_n(byte_lane_enables_n),
    .lanes_oe(lanes_oe), .cycle_start_strobe_n(cycle_start_strobe_n),
    .cycle_start_strobe_dup_n(cycle_start_strobe_dup_n), .strobe_oe(strobe_oe),
    .addr_parity_error_out_n(addr_parity_error_out_n), .snoop_valid(snoop_valid),
    .snoop_addr(snoop_addr), .core_ratio_select(core_ratio_select),
    .core_ratio_x2(core_ratio_x2));
  cba_chipset_model far (.ref_clk, .rst, .cycle_start_strobe_n, .burst(req.burst),
    .wait_states(ws), .na_en, .transfer_ready_in_n, .next_address_ok_n);

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic issue(input logic [31:3] a, input logic [7:0] ln);
    int i = 0;
    req = '{a, ln, 1'b0, 1'b0};
    req_valid = 1;
    #1;
    while (req_ready !== 1'b1 && i++ < 20) @(negedge ref_clk);
    @(negedge ref_clk);
    req_valid = 0;
  endtask
  // s is the edge that launched the strobe
  task automatic wait_strobe(output int s);
    for (int i = 0; i < 4 && cycle_start_strobe_n !== 1'b0; i++) @(negedge ref_clk);
    s = cyc - 1;
    check(cycle_start_strobe_n === 1'b0, "no strobe");
    check(cycle_start_strobe_dup_n === 1'b0, "no dup strobe");
  endtask

  task automatic t_ratio;
    logic [2:0] s [8] = '{3'h4, 3'h5, 3'h7, 3'h2, 3'h0, 3'h1, 3'h3, 3'h6};
    logic [3:0] r [8] = '{RATIO_2P5, RATIO_3P0, RATIO_3P5, RATIO_4P0,
                          RATIO_4P5, RATIO_5P0, RATIO_5P5, RATIO_6P0};
    for (int i = 0; i < 8; i++) begin
      core_ratio_select = s[i];
      rst = 1;
      cycles(2);
      check(cycle_start_strobe_n & addr_parity_error_out_n, "reset outputs");
      rst = 0;
      cycles(STRAP_HOLD_CLKS);
      core_ratio_select = ~s[i];
      cycles(2);
      check(core_ratio_x2 === r[i], "ratio decode");
    end
    core_ratio_select = STRAP_DEFAULT;
  endtask
  task automatic t_single;
    int s, s2;
    logic [31:3] a = 29'h0a5f_00c3;
    issue(a, 8'h0f);
    wait_strobe(s);
    check(addr_out === a && byte_lane_enables_n === 8'h0f, "addr or lanes");
    check(^{addr_parity_out, addr_out[31:5]} === 1'b0, "parity");
    cycles(1);
    check(cycle_start_strobe_n & cycle_start_strobe_dup_n, "strobe long");
    check(addr_out === a && byte_lane_enables_n === 8'h0f, "not held");
    issue(~a, 8'h80);
    wait_strobe(s2);
    check(s2 > last_rdy && last_rdy > s, "no idle state");
    cycles(8);
    check(addr_oe && addr_out === ~a && ^{addr_parity_out, addr_out[31:5]} === 1'b0,
      "idle drive");
  endtask
  task automatic t_pipe;
    int s, s2;
    ws = 4'h4;
    na_en = 1;
    issue(29'h1000_0001, 8'h00);
    wait_strobe(s);
    issue(29'h0000_0fff, 8'hff);
    wait_strobe(s2);
    check(last_na > s && s2 > last_na && s2 <= last_na + 2 && last_rdy < s, "pipe");
    na_en = 0;
    ws = 4'h2;
    cycles(16);
  endtask
  task automatic t_release;
    address_release_req = 1;
    cycles(1);
    check({addr_oe, addr_parity_oe, lanes_oe, strobe_oe} === 4'h3, "release");
    req = '{29'h0, 8'hff, 1'b0, 1'b0};
    req_valid = 1;
    #0.5;
    check(req_ready === 1'b0, "start under release");
    req.writeback = 1;
    #0.5;
    check(req_ready === 1'b1, "writeback refused");
    req_valid = 0;
    for (int b = 0; b < 2; b++) begin
      snp = b ? 29'h1fff_ffe7 : 29'h0234_5678;
      snp_par = (^snp[31:5]) ^ b[0];
      external_snoop_strobe_n = 0;
      cycles(1);
      external_snoop_strobe_n = 1;
      check(snoop_valid === 1'b1 && snoop_addr === snp[31:5], "snoop addr");
      check(addr_parity_error_out_n === !b[0], "parity check");
      cycles(1);
      check(addr_parity_error_out_n & !snoop_valid, "pulse long");
    end
    address_release_req = 0;
    cycles(1);
    check(addr_oe & addr_parity_oe, "release resume");
  endtask
  task automatic t_float;
    bus_backoff_n = 0;
    cycles(1);
    check({addr_oe, addr_parity_oe, lanes_oe, strobe_oe} === 4'h0, "backoff");
    bus_backoff_n = 1;
    cycles(1);
    check({addr_oe, addr_parity_oe, lanes_oe, strobe_oe} === 4'hf, "backoff end");
    hold_req = 1;
    for (int i = 0; i < 6 && hold_grant !== 1'b1; i++) @(negedge ref_clk);
    check(hold_grant === 1'b1 && {addr_oe, lanes_oe, strobe_oe} === 3'h0, "hold");
    hold_req = 0;
    for (int i = 0; i < 6 && hold_grant !== 1'b0; i++) @(negedge ref_clk);
    check({addr_oe, addr_parity_oe, lanes_oe, strobe_oe} === 4'hf, "hold end");
  endtask

  initial begin
    cycles(4);
    rst = 0;
    cycles(2);
    t_ratio;
    t_single;
    t_pipe;
    t_release;
    t_float;
    stop_test;
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    miscompares++;
    stop_test;
  end
endmodule
